// file: hdl/ext_irq_wake_pkg.sv
/*
 * Shared constants and types for the external interrupt and wake-up logic:
 * register offsets, field positions, reset values, power modes and timing.
 * Assumes a single 40 MHz core clock and a word-aligned plain register port.
 */
package ext_irq_wake_pkg;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] MASK_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] PIN_OFS = 4'hC;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EXT_EN_BIT = 2;
    localparam int CTRL_SPECIAL_BIT = 3;
    localparam int CTRL_OTHER_EN_LSB = 8;

    localparam int ST_PENDING = 0;
    localparam int ST_PD_WAKE = 1;
    localparam int ST_IDLE_WAKE = 2;
    localparam int ST_W = 3;

    localparam int PIN_LEVEL_BIT = 0;
    localparam int PIN_PHASE_BIT = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
    localparam logic [ST_W-1:0] MASK_RST = 3'h0;
    localparam int OTHER_IRQS = 8;
    localparam logic [OTHER_IRQS-1:0] OTHER_EN_RST = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int WAKE_MIN_NS = 50;
    localparam int WAKE_MIN_RAW = (WAKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_MIN_CYCLES = (WAKE_MIN_RAW < 1) ? 1 : WAKE_MIN_RAW;
    localparam int STATE_HALF_CYCLES = 1;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_IDLE,
        MODE_POWERDOWN
    } power_mode_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic level;
        logic rise;
        logic wake;
        logic phase2;
    } sample_s;

endpackage

// file: hdl/state_sampler.sv
/*
 * Two-phase state clock generator and interrupt pin sampler.
 * Assumes the pin is synchronous to core_clk; the state clock stops while
 * the stop input is high, but the wake-up hold counter keeps running.
 */
`timescale 1ns/1ps
module state_sampler
    import ext_irq_wake_pkg::*;
#(
    parameter int HALF_CYCLES = STATE_HALF_CYCLES,
    parameter int WAKE_CYCLES = WAKE_MIN_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic stopped,
    input wire logic wake_arm,
    input wire logic ext_irq_pin,
    output logic clock_output_pin,
    output sample_s sample
);

    // ------------------------------------------------------------------
    // state clock
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);

    logic [CNT_W-1:0] half_cnt_reg;
    logic [CNT_W-1:0] hi_cnt_reg;
    logic phase2_reg;
    logic level_reg;
    logic rise_reg;
    logic wake_reg;

    wire half_end = (half_cnt_reg == HALF_LAST);
    wire sample_now = phase2_reg && half_end && !stopped;
    wire hi_hold = wake_arm && ext_irq_pin;
    wire hi_full = (hi_cnt_reg == WAKE_LAST);
    wire [CNT_W-1:0] half_cnt_next = (stopped || half_end) ? '0 : half_cnt_reg + 1'b1;
    wire [CNT_W-1:0] hi_cnt_next = !hi_hold ? '0 : (hi_full ? hi_cnt_reg : hi_cnt_reg + 1'b1);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            half_cnt_reg <= '0;
            phase2_reg <= 1'b0;
        end else begin
            half_cnt_reg <= half_cnt_next;
            phase2_reg <= stopped ? 1'b0 : (half_end ? !phase2_reg : phase2_reg);
        end
    end

    // ------------------------------------------------------------------
    // phase 2 sampling and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            if (sample_now) begin
                level_reg <= ext_irq_pin;
            end
            rise_reg <= sample_now && ext_irq_pin && !level_reg;
        end
    end

    // ------------------------------------------------------------------
    // powerdown hold timer, runs on core_clk while the state clock is off
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hi_cnt_reg <= '0;
            wake_reg <= 1'b0;
        end else begin
            hi_cnt_reg <= hi_cnt_next;
            wake_reg <= hi_hold && hi_full && !wake_reg;
        end
    end

    assign clock_output_pin = phase2_reg;
    assign sample = '{level: level_reg, rise: rise_reg, wake: wake_reg, phase2: phase2_reg};

endmodule

// file: hdl/external_interrupt_wake.sv
/*
 * External interrupt input with wake-up from idle and powerdown, plus a
 * small register file reached over a plain strobe port.
 * Assumes a single core clock, synchronous inputs, and a CPU that acknowledges
 * the external interrupt service with a one-cycle pulse.
 */
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module external_interrupt_wake
    import ext_irq_wake_pkg::*;
#(
    parameter int N_OTHER = OTHER_IRQS,
    parameter int WAKE_CYCLES = WAKE_MIN_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ext_irq_pin,
    input wire logic [N_OTHER-1:0] other_irq,
    input wire logic isr_ack,
    input bus_req_s bus_req,
    output logic [DATA_W-1:0] rdata,
    output logic irq,
    output logic clock_output_pin,
    output power_mode_e power_mode,
    output logic ext_isr_req,
    output logic resume_next
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    power_mode_e mode_reg;
    power_mode_e mode_next;
    logic ext_en_reg;
    logic special_reg;
    logic [N_OTHER-1:0] other_en_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic irq_reg;
    logic isr_req_reg;
    logic resume_reg;
    sample_s smp;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    wire wr_ctrl = bus_req.wr && hit(bus_req.addr, CTRL_OFS);
    wire wr_status = bus_req.wr && hit(bus_req.addr, STATUS_OFS);
    wire wr_mask = bus_req.wr && hit(bus_req.addr, MASK_OFS);
    wire rd_ctrl = hit(bus_req.addr, CTRL_OFS);
    wire rd_status = hit(bus_req.addr, STATUS_OFS);
    wire rd_mask = hit(bus_req.addr, MASK_OFS);
    wire rd_pin = hit(bus_req.addr, PIN_OFS);

    wire [1:0] mode_wr_code = bus_req.wdata[CTRL_MODE_LSB +: 2];
    wire mode_wr_legal = (mode_wr_code != 2'h3);

    // ------------------------------------------------------------------
    // pin sampler and state clock
    // ------------------------------------------------------------------
    wire in_powerdown = (mode_reg == MODE_POWERDOWN);
    wire in_idle = (mode_reg == MODE_IDLE);
    wire pd_wake_arm = in_powerdown && special_reg;

    state_sampler #(
        .HALF_CYCLES(STATE_HALF_CYCLES),
        .WAKE_CYCLES(WAKE_CYCLES)
    ) u_sampler (
        .core_clk(core_clk),
        .reset(reset),
        .stopped(in_powerdown),
        .wake_arm(pd_wake_arm),
        .ext_irq_pin(ext_irq_pin),
        .clock_output_pin(clock_output_pin),
        .sample(smp)
    );

    // ------------------------------------------------------------------
    // wake-up and pending flag
    // ------------------------------------------------------------------
    // edges are taken while the state clock runs; the sampler is halted in powerdown
    wire edge_set = smp.rise && !in_powerdown;
    wire pd_wake = smp.wake && pd_wake_arm;
    wire pd_wake_isr = pd_wake && ext_en_reg;
    wire pending_set = edge_set || pd_wake_isr;
    wire ext_active = status_reg[ST_PENDING] && ext_en_reg;
    wire idle_wake = in_idle && (|(other_irq & other_en_reg) || ext_active);

    wire [ST_W-1:0] st_set = {idle_wake, pd_wake, pending_set};
    wire [ST_W-1:0] st_clr_sw = wr_status ? bus_req.wdata[ST_W-1:0] : '0;
    wire [ST_W-1:0] st_clr_ack = {{(ST_W-1){1'b0}}, isr_ack};
    // a set in the same cycle as a clear wins
    wire [ST_W-1:0] status_next = (status_reg & ~(st_clr_sw | st_clr_ack)) | st_set;

    always_comb begin
        mode_next = mode_reg;
        if (wr_ctrl && mode_wr_legal) begin
            mode_next = power_mode_e'(mode_wr_code);
        end
        if (pd_wake || idle_wake) begin
            mode_next = MODE_NORMAL;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [DATA_W-1:0] ctrl_view = DATA_W'({other_en_reg, 4'h0, special_reg, ext_en_reg, 2'(mode_reg)});
    wire [DATA_W-1:0] status_view = DATA_W'(status_reg);
    wire [DATA_W-1:0] mask_view = DATA_W'(mask_reg);
    wire [DATA_W-1:0] pin_view = DATA_W'({smp.phase2, smp.level});
    wire [DATA_W-1:0] rdata_next = !bus_req.rd ? '0 :
                                   rd_ctrl ? ctrl_view :
                                   rd_status ? status_view :
                                   rd_mask ? mask_view :
                                   rd_pin ? pin_view : '0;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_reg <= MODE_NORMAL;
            ext_en_reg <= 1'b0;
            special_reg <= 1'b0;
            other_en_reg <= OTHER_EN_RST;
        end else begin
            mode_reg <= mode_next;
            if (wr_ctrl) begin
                ext_en_reg <= bus_req.wdata[CTRL_EXT_EN_BIT];
                special_reg <= bus_req.wdata[CTRL_SPECIAL_BIT];
                other_en_reg <= bus_req.wdata[CTRL_OTHER_EN_LSB +: N_OTHER];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_reg <= STATUS_RST;
            mask_reg <= MASK_RST;
        end else begin
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= bus_req.wdata[ST_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= '0;
            irq_reg <= 1'b0;
            isr_req_reg <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            irq_reg <= |(status_next & mask_reg);
            isr_req_reg <= status_next[ST_PENDING] && ext_en_reg && (mode_next == MODE_NORMAL);
            resume_reg <= pd_wake && !ext_en_reg;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign power_mode = mode_reg;
    assign ext_isr_req = isr_req_reg;
    assign resume_next = resume_reg;

endmodule

// file: tb/external_interrupt_wake_sva.sv
/* Concurrent checks on the ports of external_interrupt_wake.
   Assumes one core clock, reset active high, and is attached by the bind at the foot. */
`timescale 1ns/1ps
module external_interrupt_wake_sva
    import ext_irq_wake_pkg::*;
#(
    parameter int N_OTHER = OTHER_IRQS,
    parameter int WAKE_CYCLES = WAKE_MIN_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ext_irq_pin,
    input wire logic [N_OTHER-1:0] other_irq,
    input wire logic isr_ack,
    input bus_req_s bus_req,
    input logic [DATA_W-1:0] rdata,
    input logic irq,
    input logic clock_output_pin,
    input power_mode_e power_mode,
    input logic ext_isr_req,
    input logic resume_next
);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence pd_left;
        $past(power_mode) == MODE_POWERDOWN && power_mode == MODE_NORMAL && !$past(bus_req.wr);
    endsequence
    sequence one_pulse;
        resume_next ##1 !resume_next;
    endsequence
    chk_pd_clk_low: assert property (
        power_mode == MODE_POWERDOWN && $past(power_mode) == MODE_POWERDOWN |-> !clock_output_pin)
        else $error("state clock runs in powerdown");
    chk_pend_normal: assert property ($rose(ext_isr_req) |-> power_mode == MODE_NORMAL)
        else $error("service request outside normal mode");
    chk_pend_hold: assert property (
        ext_isr_req && !isr_ack && !bus_req.wr |=> ext_isr_req)
        else $error("pending request dropped without clear");
    chk_irq_sticky: assert property (
        $fell(irq) |-> $past(bus_req.wr) || $past(bus_req.wr, 2) || $past(isr_ack) || $past(isr_ack, 2))
        else $error("interrupt fell without clear");
    chk_pd_wake_pin: assert property (pd_left |-> $past(ext_irq_pin, 2) && $past(ext_irq_pin, 3))
        else $error("powerdown left without two high pin cycles");
    chk_resume_pulse: assert property ($rose(resume_next) |-> one_pulse)
        else $error("resume pulse not one cycle");
    chk_resume_excl: assert property (
        resume_next |-> !ext_isr_req && power_mode == MODE_NORMAL && $past(power_mode) == MODE_POWERDOWN)
        else $error("resume pulse outside disabled powerdown wake");
    chk_idle_wake: assert property (
        $past(power_mode) == MODE_IDLE && power_mode == MODE_NORMAL && !$past(bus_req.wr)
        |-> ((|$past(other_irq)) || ext_isr_req) or ##1 ext_isr_req)
        else $error("idle left without enabled request");
    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == '0)
        else $error("read data outside read slot");
    chk_clk_toggle: assert property (
        power_mode != MODE_POWERDOWN && $past(power_mode) != MODE_POWERDOWN && !$past(reset)
        |-> clock_output_pin != $past(clock_output_pin))
        else $error("state clock stalled outside powerdown");
endmodule
bind external_interrupt_wake external_interrupt_wake_sva #(.N_OTHER(N_OTHER), .WAKE_CYCLES(WAKE_CYCLES)) chk_i (
    .core_clk(core_clk), .reset(reset), .ext_irq_pin(ext_irq_pin), .other_irq(other_irq),
    .isr_ack(isr_ack), .bus_req(bus_req), .rdata(rdata), .irq(irq), .clock_output_pin(clock_output_pin),
    .power_mode(power_mode), .ext_isr_req(ext_isr_req), .resume_next(resume_next));

// file: tb/ext_irq_source.sv
/* Outside interrupt source that drives the pin high for a commanded count.
   Assumes fire is a one-cycle request from the bench. */
`timescale 1ns/1ps
module ext_irq_source (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic fire,
    input wire logic [7:0] hold,
    output logic ext_irq_pin
);
    // ------------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------------
    logic [7:0] left_reg;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            left_reg <= 8'h00;
        end else if (fire) begin
            left_reg <= hold;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    assign ext_irq_pin = (left_reg != 8'h00);
endmodule

// file: tb/external_interrupt_wake_bench.sv
/* Self-checking bench for external_interrupt_wake with a pin source model.
   Assumes the design's package and the checker bind are compiled first. */
`timescale 1ns/1ps
module external_interrupt_wake_bench
    import ext_irq_wake_pkg::*;
;
    // ------------------------------------------------------------------
    // harness
    // ------------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic fire = 1'b0;
    logic [7:0] hold = 8'h00;
    logic [7:0] other_irq = 8'h00;
    logic isr_ack = 1'b0;
    bus_req_s bus_req = '0;
    logic ext_irq_pin, irq, clock_output_pin, ext_isr_req, resume_next, rn;
    logic [31:0] rdata, d;
    power_mode_e power_mode;
    logic s_irq, s_req, s_clk;
    power_mode_e s_mode;
    int err_total = 0;
    int total_checks = 0;
    always #12.5 core_clk = ~core_clk;
    ext_irq_source src (.core_clk(core_clk), .reset(reset), .fire(fire), .hold(hold), .ext_irq_pin(ext_irq_pin));
    external_interrupt_wake dut (.core_clk(core_clk), .reset(reset), .ext_irq_pin(ext_irq_pin),
        .other_irq(other_irq), .isr_ack(isr_ack), .bus_req(bus_req), .rdata(rdata), .irq(irq),
        .clock_output_pin(clock_output_pin), .power_mode(power_mode), .ext_isr_req(ext_isr_req),
        .resume_next(resume_next));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1 d = rdata;
        @(posedge core_clk);
    endtask
    task automatic fire_pin(input logic [7:0] h);
        fire <= 1'b1;
        hold <= h;
        @(posedge core_clk);
        fire <= 1'b0;
    endtask
    // samples the outputs just after the current edge, resumes at the next edge
    task automatic grab;
        #1;
        s_irq = irq;
        s_req = ext_isr_req;
        s_clk = clock_output_pin;
        s_mode = power_mode;
        @(posedge core_clk);
    endtask
    // sel 1 waits for the service request, sel 0 for the given mode
    task automatic wait_for(input bit sel, input power_mode_e m);
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            #1;
            if (sel ? ext_isr_req === 1'b1 : power_mode === m) break;
        end
        rn = resume_next;
        @(posedge core_clk);
        if (i == 50) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, power_mode, m);
            end_sim();
        end
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd(STATUS_OFS);
        chk(d, 32'h0);
        wr(MASK_OFS, 32'h7);
        rd(MASK_OFS);
        chk(d, 32'h7);
        rd(4'h2);
        chk(d, 32'h0);
        // mode code 3 is refused while the other control fields still land
        wr(CTRL_OFS, 32'h0000010F);
        rd(CTRL_OFS);
        chk(d, 32'h0000010C);
        $display("test regs done");
    endtask
    task automatic t_edge;
        wr(CTRL_OFS, 32'h0000000C);
        fire_pin(8'h02);
        wait_for(1'b1, MODE_NORMAL);
        rd(STATUS_OFS);
        chk(d, 32'h1);
        repeat (6) @(posedge core_clk);
        grab();
        chk(s_req, 1'b1);
        isr_ack <= 1'b1;
        @(posedge core_clk);
        isr_ack <= 1'b0;
        rd(STATUS_OFS);
        chk(d, 32'h0);
        grab();
        chk(s_req, 1'b0);
        // short enough that the pin is low again before powerdown is entered
        fire_pin(8'h06);
        wait_for(1'b1, MODE_NORMAL);
        wr(MASK_OFS, 32'h0);
        grab();
        chk(s_irq, 1'b0);
        wr(MASK_OFS, 32'h7);
        grab();
        chk(s_irq, 1'b1);
        wr(STATUS_OFS, 32'h1);
        rd(STATUS_OFS);
        chk(d, 32'h0);
        grab();
        chk(s_irq, 1'b0);
        $display("test edge done");
    endtask
    task automatic t_pd;
        wr(CTRL_OFS, 32'h0000000A);
        repeat (4) @(posedge core_clk);
        grab();
        chk(s_clk, 1'b0);
        fire_pin(8'h01);
        repeat (8) @(posedge core_clk);
        grab();
        chk(s_mode, MODE_POWERDOWN);
        fire_pin(8'h02);
        wait_for(1'b0, MODE_NORMAL);
        chk(rn, 1'b1);
        grab();
        chk(s_req, 1'b0);
        rd(STATUS_OFS);
        chk(d, 32'h2);
        wr(STATUS_OFS, 32'h7);
        wr(CTRL_OFS, 32'h0000000E);
        fire_pin(8'h02);
        wait_for(1'b1, MODE_NORMAL);
        grab();
        chk(s_mode, MODE_NORMAL);
        rd(STATUS_OFS);
        chk(d, 32'h3);
        wr(STATUS_OFS, 32'h7);
        wr(CTRL_OFS, 32'h00000006);
        fire_pin(8'h04);
        repeat (10) @(posedge core_clk);
        grab();
        chk(s_mode, MODE_POWERDOWN);
        wr(CTRL_OFS, 32'h0);
        $display("test powerdown done");
    endtask
    task automatic t_idle;
        wr(CTRL_OFS, 32'h00000101);
        other_irq <= 8'h02;
        repeat (6) @(posedge core_clk);
        grab();
        chk(s_mode, MODE_IDLE);
        other_irq <= 8'h03;
        wait_for(1'b0, MODE_NORMAL);
        other_irq <= 8'h00;
        rd(STATUS_OFS);
        chk(d, 32'h4);
        $display("test idle done");
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_edge();
        t_pd();
        t_idle();
        end_sim();
    end
endmodule
